/* common/ipf_pkg.sv */
////////////////////////////////////////////////////////////////////////////////
// Shared constants for the interrupt priority field bank.
package ipf_pkg;

	// Register byte addresses on the APB bus.
	localparam logic [7:0] ext_inputs_offset      = 8'h00;
	localparam logic [7:0] calendar_offset        = 8'h04;
	localparam logic [7:0] checksum_serial_offset = 8'h08;
	localparam logic [7:0] request_status_offset  = 8'h0c;

	// Field positions, the low bit of each three-bit field.
	localparam int ext_four_lsb      = 8;
	localparam int ext_three_lsb     = 4;
	localparam int calendar_lsb      = 8;
	localparam int checksum_lsb      = 12;
	localparam int serial_two_lsb    = 8;
	localparam int serial_one_lsb    = 4;

	// Field geometry and reset value.
	localparam int field_width = 3;
	localparam int reg_width   = 16;
	localparam int source_count = 6;
	localparam logic [2:0] field_reset    = 3'h4;
	localparam logic [2:0] level_disabled = 3'h0;

	// Source numbering on the per-source ports.
	localparam int src_ext_three  = 0;
	localparam int src_ext_four   = 1;
	localparam int src_calendar   = 2;
	localparam int src_checksum   = 3;
	localparam int src_serial_one = 4;
	localparam int src_serial_two = 5;

	// Register select codes between the bus slave and the register bank.
	typedef enum logic [2:0] {
		sel_ext_inputs      = 3'b000,
		sel_calendar        = 3'b001,
		sel_checksum_serial = 3'b010,
		sel_request_status  = 3'b011,
		sel_none            = 3'b111
	} ipf_sel_type;

	// Bus slave states.
	typedef enum logic [0:0] {
		st_idle   = 1'b0,
		st_access = 1'b1
	} ipf_bus_state_type;

	// Maps a byte address to a register select code.
	function automatic ipf_sel_type decode_addr(input logic [7:0] addr);
		if (addr == ext_inputs_offset) begin
			return sel_ext_inputs;
		end else if (addr == calendar_offset) begin
			return sel_calendar;
		end else if (addr == checksum_serial_offset) begin
			return sel_checksum_serial;
		end else if (addr == request_status_offset) begin
			return sel_request_status;
		end else begin
			return sel_none;
		end
	endfunction : decode_addr

endpackage : ipf_pkg

/* common/ipf_reg_if.sv */
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Register access path between the bus slave and the register bank.
interface ipf_reg_if;
	ipf_pkg::ipf_sel_type sel;
	logic                 wr_stb;
	logic [15:0]          wdata;
	logic [15:0]          rdata;

	modport slave (
		output sel,
		output wr_stb,
		output wdata,
		input  rdata
	);

	modport bank (
		input  sel,
		input  wr_stb,
		input  wdata,
		output rdata
	);
endinterface : ipf_reg_if

/* logic/ipf_source_gate.sv */
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Turns one source's flag, enable and priority code into a request and level.
module ipf_source_gate (
	// Source state
	input  wire logic       flag,
	input  wire logic       enable,
	input  wire logic [2:0] code,
	// To the arbitration logic
	output logic            req,
	output logic [2:0]      level
);

	////////////////////////////////////////////////////////////////////////////
	// The code is the level itself: seven is highest, one lowest, zero masks.
	always_comb begin
		level = code;
		req   = flag && enable && (code != ipf_pkg::level_disabled);
	end

endmodule : ipf_source_gate

/* logic/ipf_apb_slave.sv */
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// APB slave front end; answers every access with no wait state.
module ipf_apb_slave (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// APB
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Register bank
	ipf_reg_if.slave         regs
);

	ipf_pkg::ipf_bus_state_type state_reg;
	ipf_pkg::ipf_bus_state_type state_next;
	logic [31:0]                prdata_reg;
	logic [31:0]                prdata_next;
	logic                       err_reg;
	logic                       err_next;

	////////////////////////////////////////////////////////////////////////////
	// Decode is live from the address; the bank reads it during setup.
	always_comb begin
		regs.sel    = ipf_pkg::decode_addr(paddr);
		regs.wdata  = pwdata[15:0];
		regs.wr_stb = psel && penable && pwrite && (state_reg == ipf_pkg::st_access);
	end

	// Setup captures read data and the error answer; access ends in one cycle.
	always_comb begin
		state_next  = state_reg;
		prdata_next = prdata_reg;
		err_next    = err_reg;
		case (state_reg)
			ipf_pkg::st_idle: begin
				if (psel && !penable) begin
					state_next  = ipf_pkg::st_access;
					prdata_next = pwrite ? 32'h0000_0000 : {16'h0000, regs.rdata};
					err_next    = (regs.sel == ipf_pkg::sel_none);
				end
			end
			ipf_pkg::st_access: begin
				state_next = ipf_pkg::st_idle;
			end
			default: begin
				state_next = ipf_pkg::st_idle;
			end
		endcase
	end

	// State registers.
	always_ff @(posedge clk) begin
		if (reset) begin
			state_reg  <= ipf_pkg::st_idle;
			prdata_reg <= 32'h0000_0000;
			err_reg    <= 1'b0;
		end else begin
			state_reg  <= state_next;
			prdata_reg <= prdata_next;
			err_reg    <= err_next;
		end
	end

	// Ready is high for exactly the first access cycle.
	always_comb begin
		pready  = (state_reg == ipf_pkg::st_access);
		pslverr = pready && err_reg;
		prdata  = prdata_reg;
	end

endmodule : ipf_apb_slave

/* logic/ipf_priority_top.sv */
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////////////
// Priority field bank for six interrupt sources, reached over APB.
module ipf_priority_top #(
	parameter int n_sources = 6
) (
	// Clock and reset
	input  wire logic                   clk,
	input  wire logic                   reset,
	// APB
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [7:0]             paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	// Sources
	input  wire logic [n_sources-1:0]   src_flag,
	input  wire logic [n_sources-1:0]   src_enable,
	// Arbitration side
	output logic      [n_sources-1:0]   src_req,
	output logic      [3*n_sources-1:0] src_level
);

	ipf_reg_if regs ();

	// Priority codes, one per source.
	logic [2:0] ext_three_priority_reg;
	logic [2:0] ext_three_priority_next;
	logic [2:0] ext_four_priority_reg;
	logic [2:0] ext_four_priority_next;
	logic [2:0] calendar_clock_priority_reg;
	logic [2:0] calendar_clock_priority_next;
	logic [2:0] checksum_error_priority_reg;
	logic [2:0] checksum_error_priority_next;
	logic [2:0] serial_one_error_priority_reg;
	logic [2:0] serial_one_error_priority_next;
	logic [2:0] serial_two_error_priority_reg;
	logic [2:0] serial_two_error_priority_next;
	logic [2:0] code_vec [n_sources];

	////////////////////////////////////////////////////////////////////////////
	// Bus front end.
	ipf_apb_slave u_apb (
		.clk     (clk),
		.reset   (reset),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.prdata  (prdata),
		.pready  (pready),
		.pslverr (pslverr),
		.regs    (regs.slave)
	);

	////////////////////////////////////////////////////////////////////////////
	// Writes pick out only the implemented fields; all other bits are dropped.
	always_comb begin
		ext_three_priority_next        = ext_three_priority_reg;
		ext_four_priority_next         = ext_four_priority_reg;
		calendar_clock_priority_next   = calendar_clock_priority_reg;
		checksum_error_priority_next   = checksum_error_priority_reg;
		serial_one_error_priority_next = serial_one_error_priority_reg;
		serial_two_error_priority_next = serial_two_error_priority_reg;
		if (regs.wr_stb) begin
			if (regs.sel == ipf_pkg::sel_ext_inputs) begin
				ext_four_priority_next  = regs.wdata[ipf_pkg::ext_four_lsb +: 3];
				ext_three_priority_next = regs.wdata[ipf_pkg::ext_three_lsb +: 3];
			end else if (regs.sel == ipf_pkg::sel_calendar) begin
				// Only bits ten to eight are stored; the rest is discarded.
				calendar_clock_priority_next = regs.wdata[ipf_pkg::calendar_lsb +: 3];
			end else if (regs.sel == ipf_pkg::sel_checksum_serial) begin
				checksum_error_priority_next   = regs.wdata[ipf_pkg::checksum_lsb +: 3];
				serial_two_error_priority_next = regs.wdata[ipf_pkg::serial_two_lsb +: 3];
				serial_one_error_priority_next = regs.wdata[ipf_pkg::serial_one_lsb +: 3];
			end
		end
	end

	// Field registers, all loading level four at reset.
	always_ff @(posedge clk) begin
		if (reset) begin
			ext_three_priority_reg        <= ipf_pkg::field_reset;
			ext_four_priority_reg         <= ipf_pkg::field_reset;
			calendar_clock_priority_reg   <= ipf_pkg::field_reset;
			checksum_error_priority_reg   <= ipf_pkg::field_reset;
			serial_one_error_priority_reg <= ipf_pkg::field_reset;
			serial_two_error_priority_reg <= ipf_pkg::field_reset;
		end else begin
			ext_three_priority_reg        <= ext_three_priority_next;
			ext_four_priority_reg         <= ext_four_priority_next;
			calendar_clock_priority_reg   <= calendar_clock_priority_next;
			checksum_error_priority_reg   <= checksum_error_priority_next;
			serial_one_error_priority_reg <= serial_one_error_priority_next;
			serial_two_error_priority_reg <= serial_two_error_priority_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read mux; unimplemented bit positions are built as constant zero.
	always_comb begin
		regs.rdata = 16'h0000;
		if (regs.sel == ipf_pkg::sel_ext_inputs) begin
			regs.rdata[ipf_pkg::ext_four_lsb +: 3]  = ext_four_priority_reg;
			regs.rdata[ipf_pkg::ext_three_lsb +: 3] = ext_three_priority_reg;
		end else if (regs.sel == ipf_pkg::sel_calendar) begin
			regs.rdata[ipf_pkg::calendar_lsb +: 3] = calendar_clock_priority_reg;
		end else if (regs.sel == ipf_pkg::sel_checksum_serial) begin
			regs.rdata[ipf_pkg::checksum_lsb +: 3]   = checksum_error_priority_reg;
			regs.rdata[ipf_pkg::serial_two_lsb +: 3] = serial_two_error_priority_reg;
			regs.rdata[ipf_pkg::serial_one_lsb +: 3] = serial_one_error_priority_reg;
		end else if (regs.sel == ipf_pkg::sel_request_status) begin
			// Live request state, so software can see what is being raised.
			regs.rdata[n_sources-1:0] = src_req;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Gather codes in source order for the per-source gates.
	always_comb begin
		code_vec[ipf_pkg::src_ext_three]  = ext_three_priority_reg;
		code_vec[ipf_pkg::src_ext_four]   = ext_four_priority_reg;
		code_vec[ipf_pkg::src_calendar]   = calendar_clock_priority_reg;
		code_vec[ipf_pkg::src_checksum]   = checksum_error_priority_reg;
		code_vec[ipf_pkg::src_serial_one] = serial_one_error_priority_reg;
		code_vec[ipf_pkg::src_serial_two] = serial_two_error_priority_reg;
	end

	// One gate per source masks level-zero sources and passes the level on.
	for (genvar i = 0; i < n_sources; i++) begin : g_gate
		ipf_source_gate u_gate (
			.flag   (src_flag[i]),
			.enable (src_enable[i]),
			.code   (code_vec[i]),
			.req    (src_req[i]),
			.level  (src_level[3*i +: 3])
		);
	end

endmodule : ipf_priority_top

/* sim/ipf_priority_checker.sv */
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Watches the priority bank ports for register and request behaviour.
module ipf_priority_checker #(
	parameter int n_sources = 6
) (
	// Clock and reset
	input wire logic                   clk,
	input wire logic                   reset,
	// APB
	input wire logic                   psel,
	input wire logic                   penable,
	input wire logic                   pwrite,
	input wire logic [7:0]             paddr,
	input wire logic [31:0]            pwdata,
	input wire logic [31:0]            prdata,
	input wire logic                   pready,
	input wire logic                   pslverr,
	// Sources
	input wire logic [n_sources-1:0]   src_flag,
	input wire logic [n_sources-1:0]   src_enable,
	input wire logic [n_sources-1:0]   src_req,
	input wire logic [3*n_sources-1:0] src_level
);
	logic [n_sources-1:0] nz;
	// Marks sources whose stored code is not zero.
	always_comb begin
		for (int i = 0; i < n_sources; i++) begin
			nz[i] = |src_level[3*i +: 3];
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	sequence s_setup; psel && !penable; endsequence
	sequence s_access; psel && penable; endsequence
	sequence s_cal(bit w); s_access && pready && pwrite == w && paddr == 8'h04; endsequence
	property p_ready; s_setup ##1 s_access |-> pready; endproperty
	property p_req; src_req == (src_flag & src_enable & nz); endproperty
	property p_cal_wr; s_cal(1'b1) |=> src_level[8:6] == $past(pwdata[10:8]); endproperty
	property p_cal_rd; s_cal(1'b0) |-> prdata[10:8] == src_level[8:6]; endproperty
	property p_cal_hi; s_cal(1'b0) |-> prdata[15:11] == 5'h00; endproperty
	property p_cal_lo; s_cal(1'b0) |-> prdata[7:0] == 8'h00; endproperty
	property p_rst; $fell(reset) |-> src_level == {n_sources{3'h4}}; endproperty
	property p_err;
		s_access && pready |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c});
	endproperty
	a_ready: assert property (p_ready) else $error("pready missing after setup");
	a_req: assert property (p_req) else $error("request does not follow code");
	a_cal_wr: assert property (p_cal_wr) else $error("calendar code not stored");
	a_cal_rd: assert property (p_cal_rd) else $error("calendar code misread");
	a_cal_hi: assert property (p_cal_hi) else $error("calendar high bits set");
	a_cal_lo: assert property (p_cal_lo) else $error("calendar low byte set");
	a_rst: assert property (p_rst) else $error("reset code wrong");
	a_err: assert property (p_err) else $error("slave error wrong");
endmodule : ipf_priority_checker

bind ipf_priority_top ipf_priority_checker #(.n_sources(n_sources)) u_chk (.clk(clk),
	.reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.src_flag(src_flag), .src_enable(src_enable), .src_req(src_req), .src_level(src_level));

/* sim/tb_top.sv */
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Self-checking bench for the priority field bank.
module tb_top;
	logic        clk, reset, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr, a;
	logic [31:0] pwdata, prdata, d;
	logic [5:0]  src_flag, src_enable, src_req;
	logic [17:0] src_level;
	logic [2:0]  code [6];
	logic [32:0] expq [$];
	int          n_fail, compares, cycles;
	integer      seed = 32'h8d929a73;

	ipf_priority_top #(.n_sources(6)) dut (.clk(clk), .reset(reset), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .src_flag(src_flag), .src_enable(src_enable),
		.src_req(src_req), .src_level(src_level));

	// Free-running 200 MHz clock.
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Counts a comparison and reports a mismatch.
	task check(input string name, input logic [32:0] seen, input logic [32:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// Prints the counts and the verdict, then stops.
	task results;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : results

	// Expected {pslverr, prdata} worked out from the model codes.
	function automatic logic [32:0] expv(input logic [7:0] ad);
		logic [31:0] v;
		v = 32'h0;
		case (ad)
			ipf_pkg::ext_inputs_offset: v = {21'h0, code[1], 1'b0, code[0], 4'h0};
			ipf_pkg::calendar_offset: v = {21'h0, code[2], 8'h00};
			ipf_pkg::checksum_serial_offset: v = {17'h0, code[3], 1'b0, code[5], 1'b0, code[4], 4'h0};
			ipf_pkg::request_status_offset: begin
				for (int i = 0; i < 6; i++) v[i] = src_flag[i] & src_enable[i] & (code[i] != 3'h0);
			end
			default: return {1'b1, 32'h0};
		endcase
		return {1'b0, v};
	endfunction : expv

	// One APB transfer, held until pready is sampled high.
	task apb(input logic w, input logic [7:0] ad, input logic [31:0] dt);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= dt;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb

	// Write and keep the model codes in step.
	task wr(input logic [7:0] ad, input logic [31:0] dt);
		apb(1'b1, ad, dt);
		case (ad)
			8'h00: {code[1], code[0]} = {dt[10:8], dt[6:4]};
			8'h04: code[2] = dt[10:8];
			8'h08: {code[3], code[5], code[4]} = {dt[14:12], dt[10:8], dt[6:4]};
			default: ;
		endcase
	endtask : wr

	// Read with the expected answer noted first.
	task rd(input logic [7:0] ad);
		expq.push_back(expv(ad));
		apb(1'b0, ad, 32'h0);
	endtask : rd

	// Compares each completed read against the oldest note.
	always @(posedge clk) begin
		if (psel && penable && pready === 1'b1 && !pwrite)
			check("read", {pslverr, prdata}, expq.pop_front());
	end

	// Cuts a hang short.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			n_fail++;
			results();
		end
	end

	// Main sequence.
	initial begin
		{reset, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
		{src_flag, src_enable} = 12'($random(seed));
		foreach (code[i]) code[i] = 3'h4;
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		for (int i = 0; i < 5; i++) rd(8'(4 * i));
		$display("reset test done");
		src_flag <= 6'h3f;
		src_enable <= 6'h3f;
		for (int c = 0; c < 8; c++) begin
			d = $random(seed);
			d[10:8] = 3'(c);
			wr(8'h04, d);
			rd(8'h04);
			rd(8'h0c);
		end
		$display("code sweep test done");
		repeat (40) begin
			d = $random(seed);
			a = {3'h0, 3'($random(seed)), 2'h0};
			{src_flag, src_enable} <= 12'($random(seed));
			wr(a, d);
			rd(a);
			rd(8'h0c);
		end
		$display("random test done");
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		foreach (code[i]) code[i] = 3'h4;
		for (int i = 0; i < 4; i++) rd(8'(4 * i));
		$display("second reset test done");
		results();
	end
endmodule : tb_top
